// ### pwmtp_pkg.sv
/*
   Constants, register map and types shared by the PWM tail block:
   test register, shared port P style GPIO and four PWM channels.
   Assumes an 8-bit register bus with one byte per address.
*/
package pwmtp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] ADDR_CH_ENABLE   = 8'h40;
   localparam logic [7:0] ADDR_CH_POLARITY = 8'h41;
   localparam logic [7:0] ADDR_PRESCALE_A  = 8'h44;
   localparam logic [7:0] ADDR_SCALE_CNT_A = 8'h45;
   localparam logic [7:0] ADDR_PRESCALE_B  = 8'h46;
   localparam logic [7:0] ADDR_SCALE_CNT_B = 8'h47;
   localparam logic [7:0] ADDR_CNT_BASE    = 8'h48;
   localparam logic [7:0] ADDR_PER_BASE    = 8'h4C;
   localparam logic [7:0] ADDR_DUTY_BASE   = 8'h50;
   localparam logic [7:0] ADDR_PWM_CTRL    = 8'h54;
   localparam logic [7:0] ADDR_TEST        = 8'h55;
   localparam logic [7:0] ADDR_PORT_DATA   = 8'h56;
   localparam logic [7:0] ADDR_PORT_DIR    = 8'h57;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes and field positions
   localparam int         NUM_CH          = 4;
   localparam int         CH_PER_SCALER   = 2;
   localparam int         TEST_CRB_BIT    = 7;
   localparam int         TEST_PCB_BIT    = 6;
   localparam int         TEST_SLB_BIT    = 5;
   localparam int         CTRL_CENTER_BIT = 3;
   localparam logic [7:0] CTRL_MASK       = 8'h1F;
   localparam logic [7:0] TEST_MASK       = 8'hE0;
   localparam logic [7:0] CH_MASK         = 8'h0F;

   ////////////////////////////////////////////////////////////////////////////
   // Reset and boundary values
   localparam logic [7:0] BYTE_ZERO    = 8'h00;
   localparam logic [7:0] BYTE_ONE     = 8'h01;
   localparam logic [7:0] BYTE_MAX     = 8'hFF;
   localparam logic [7:0] PERIOD_RST   = 8'hFF;
   localparam logic [7:0] DUTY_RST     = 8'hFF;
   localparam logic [7:0] PORT_RST     = 8'h00;
   localparam logic [7:0] DIR_RST      = 8'h00;

   typedef logic [7:0] pwmtp_byte_t;

   typedef enum logic {
      PWMTP_DIR_UP   = 1'b0,
      PWMTP_DIR_DOWN = 1'b1
   } pwmtp_dir_e;

endpackage

// ### pwmtp_ch_if.sv
/*
   Link between the register side of the top and one PWM channel.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface pwmtp_ch_if;
   logic                  tick;
   logic                  enable;
   logic                  polarity;
   logic                  center;
   logic                  cnt_wr;
   logic                  counter_reset_bypass;
   logic                  period_compare_bypass;
   pwmtp_pkg::pwmtp_byte_t period;
   pwmtp_pkg::pwmtp_byte_t duty;
   pwmtp_pkg::pwmtp_byte_t count;
   logic                  out;

   modport ctrl (
      output tick, enable, polarity, center, cnt_wr,
      output counter_reset_bypass, period_compare_bypass, period, duty,
      input  count, out
   );
   modport chan (
      input  tick, enable, polarity, center, cnt_wr,
      input  counter_reset_bypass, period_compare_bypass, period, duty,
      output count, out
   );
endinterface

// ### pwmtp_scaler.sv
/*
   Prescale down-counter: counts down from the divider value and
   gives a one-cycle tick on reaching zero, then reloads.
   Assumes load is already gated by the bypass bit.
*/
`timescale 1ns/1ns
module pwmtp_scaler (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // Divider
   input  wire pwmtp_pkg::pwmtp_byte_t divider,
   input  wire logic                   load,
   input  wire pwmtp_pkg::pwmtp_byte_t load_value,
   // State
   output      pwmtp_pkg::pwmtp_byte_t count,
   output      logic                   tick
);
   import pwmtp_pkg::*;

   pwmtp_byte_t next_count;

   assign tick = (count == BYTE_ZERO);

   always_comb begin
      if (load) begin
         next_count = load_value;
      end else if (tick) begin
         next_count = divider;
      end else begin
         next_count = count - BYTE_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         count <= BYTE_ZERO;
      end else begin
         count <= next_count;
      end
   end
endmodule // pwmtp_scaler

// ### pwmtp_channel.sv
/*
   One PWM channel: 8-bit counter, buffered period and duty, output
   with the fixed levels for extreme duty and period settings.
   Assumes tick is a one-cycle pulse from the channel's scaler.
*/
`timescale 1ns/1ns
module pwmtp_channel (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Channel link
   pwmtp_ch_if.chan  ch
);
   import pwmtp_pkg::*;

   pwmtp_byte_t cnt;
   pwmtp_byte_t per_buf;
   pwmtp_byte_t duty_buf;
   pwmtp_dir_e  dir;
   logic        out;
   pwmtp_byte_t next_cnt;
   pwmtp_dir_e  next_dir;

   wire per_zero       = (per_buf == BYTE_ZERO);
   wire at_zero        = (cnt == BYTE_ZERO);
   wire left_restart   = !ch.center && (cnt == per_buf) && !ch.period_compare_bypass;
   wire center_reload  = ch.center && (per_zero || (dir == PWMTP_DIR_DOWN && at_zero));
   wire counting       = ch.enable && ch.tick;
   wire reset_by_write = ch.cnt_wr && !ch.counter_reset_bypass;
   wire load_bufs      = !ch.enable || reset_by_write
                         || (counting && (left_restart || center_reload));
   wire duty_past_per  = (duty_buf >= per_buf);

   // Active level before polarity
   wire left_active    = (duty_buf == BYTE_MAX && !per_zero) ? 1'b0 :
                         duty_past_per ? 1'b1 : (cnt <= duty_buf);
   wire center_active  = (duty_buf == BYTE_ZERO && !per_zero) ? 1'b0 :
                         duty_past_per ? 1'b1 : (cnt < duty_buf);
   wire active         = ch.center ? center_active : left_active;
   wire next_out       = ch.polarity ? active : !active;

   ////////////////////////////////////////////////////////////////////////////
   // Counter
   always_comb begin
      next_cnt = cnt;
      next_dir = dir;
      if (reset_by_write) begin
         next_cnt = BYTE_ZERO;
         next_dir = PWMTP_DIR_UP;
      end else if (counting) begin
         if (!ch.center) begin
            next_cnt = left_restart ? BYTE_ZERO : cnt + BYTE_ONE;
         end else if (per_zero) begin
            next_cnt = BYTE_ZERO;
            next_dir = PWMTP_DIR_UP;
         end else if (dir == PWMTP_DIR_UP) begin
            if (cnt >= per_buf) begin
               next_dir = PWMTP_DIR_DOWN;
               next_cnt = cnt - BYTE_ONE;
            end else begin
               next_cnt = cnt + BYTE_ONE;
            end
         end else if (at_zero) begin
            next_dir = PWMTP_DIR_UP;
            next_cnt = BYTE_ONE;
         end else begin
            next_cnt = cnt - BYTE_ONE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt      <= BYTE_ZERO;
         dir      <= PWMTP_DIR_UP;
         per_buf  <= PERIOD_RST;
         duty_buf <= DUTY_RST;
         out      <= 1'b0;
      end else begin
         cnt <= next_cnt;
         dir <= next_dir;
         out <= next_out;
         if (load_bufs) begin
            per_buf  <= ch.period;
            duty_buf <= ch.duty;
         end
      end
   end

   assign ch.count = cnt;
   assign ch.out   = out;
endmodule // pwmtp_channel

// ### pwmtp_top.sv
/*
   PWM tail block: channel, scaler, control and test registers, the
   shared 4-pin port with PWM on pins 3 to 0, and four channels.
   Assumes a one-cycle strobe register bus and synchronous pin inputs.
*/
`timescale 1ns/1ns
module pwmtp_top (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // Register bus
   input  wire pwmtp_pkg::pwmtp_byte_t addr,
   input  wire pwmtp_pkg::pwmtp_byte_t wr_data,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output      pwmtp_pkg::pwmtp_byte_t rd_data,
   // Chip mode
   input  wire logic                   special_mode_n,
   // Port pins
   input  wire logic [3:0]             pin_in,
   output      logic [3:0]             pin_out,
   output      logic [3:0]             pin_oe_n
);
   import pwmtp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [NUM_CH-1:0] ch_enable;
   logic [NUM_CH-1:0] ch_polarity;
   pwmtp_byte_t       prescale_divider_a;
   pwmtp_byte_t       prescale_divider_b;
   pwmtp_byte_t       channel_period_value [NUM_CH];
   pwmtp_byte_t       channel_duty_value   [NUM_CH];
   pwmtp_byte_t       pwm_ctrl;
   logic [2:0]        pwm_test_control;
   pwmtp_byte_t       port_pin_data;
   pwmtp_byte_t       port_pin_direction;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   wire hit_enable   = (addr == ADDR_CH_ENABLE);
   wire hit_polarity = (addr == ADDR_CH_POLARITY);
   wire hit_pre_a    = (addr == ADDR_PRESCALE_A);
   wire hit_scnt_a   = (addr == ADDR_SCALE_CNT_A);
   wire hit_pre_b    = (addr == ADDR_PRESCALE_B);
   wire hit_scnt_b   = (addr == ADDR_SCALE_CNT_B);
   wire hit_cnt      = (addr[7:2] == ADDR_CNT_BASE[7:2]);
   wire hit_per      = (addr[7:2] == ADDR_PER_BASE[7:2]);
   wire hit_duty     = (addr[7:2] == ADDR_DUTY_BASE[7:2]);
   wire hit_ctrl     = (addr == ADDR_PWM_CTRL);
   wire hit_test     = (addr == ADDR_TEST);
   wire hit_pdata    = (addr == ADDR_PORT_DATA);
   wire hit_pdir     = (addr == ADDR_PORT_DIR);
   wire [1:0] ch_sel = addr[1:0];

   wire wr_test_ok   = wr && hit_test && !special_mode_n;

   ////////////////////////////////////////////////////////////////////////////
   // Test bits and the center-align control bit seen by the counters
   wire counter_reset_bypass  = pwm_test_control[TEST_CRB_BIT - 5];
   wire period_compare_bypass = pwm_test_control[TEST_PCB_BIT - 5];
   wire scaler_load_bypass    = pwm_test_control[TEST_SLB_BIT - 5];
   wire center_align_select   = pwm_ctrl[CTRL_CENTER_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Scalers
   pwmtp_byte_t scale_cnt_a;
   pwmtp_byte_t scale_cnt_b;
   logic        tick_a;
   logic        tick_b;
   wire         load_a = wr && hit_pre_a && !scaler_load_bypass;
   wire         load_b = wr && hit_pre_b && !scaler_load_bypass;

   pwmtp_scaler u_scaler_a (
      .clk        (clk),
      .srst       (srst),
      .divider    (prescale_divider_a),
      .load       (load_a),
      .load_value (wr_data),
      .count      (scale_cnt_a),
      .tick       (tick_a)
   );

   pwmtp_scaler u_scaler_b (
      .clk        (clk),
      .srst       (srst),
      .divider    (prescale_divider_b),
      .load       (load_b),
      .load_value (wr_data),
      .count      (scale_cnt_b),
      .tick       (tick_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Channels
   pwmtp_byte_t       ch_count [NUM_CH];
   logic [NUM_CH-1:0] ch_out;

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      pwmtp_ch_if link ();

      assign link.tick                  = (g < CH_PER_SCALER) ? tick_a : tick_b;
      assign link.enable                = ch_enable[g];
      assign link.polarity              = ch_polarity[g];
      assign link.center                = center_align_select;
      assign link.cnt_wr                = wr && hit_cnt && (ch_sel == 2'(g));
      assign link.counter_reset_bypass  = counter_reset_bypass;
      assign link.period_compare_bypass = period_compare_bypass;
      assign link.period                = channel_period_value[g];
      assign link.duty                  = channel_duty_value[g];
      assign ch_count[g]                = link.count;
      assign ch_out[g]                  = link.out;

      pwmtp_channel u_channel (
         .clk  (clk),
         .srst (srst),
         .ch   (link.chan)
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clk) begin
      if (srst) begin
         ch_enable          <= '0;
         ch_polarity        <= '0;
         prescale_divider_a <= BYTE_ZERO;
         prescale_divider_b <= BYTE_ZERO;
         pwm_ctrl           <= BYTE_ZERO;
      end else if (wr) begin
         if (hit_enable) begin
            ch_enable <= wr_data[NUM_CH-1:0];
         end
         if (hit_polarity) begin
            ch_polarity <= wr_data[NUM_CH-1:0];
         end
         if (hit_pre_a) begin
            prescale_divider_a <= wr_data;
         end
         if (hit_pre_b) begin
            prescale_divider_b <= wr_data;
         end
         if (hit_ctrl) begin
            pwm_ctrl <= wr_data & CTRL_MASK;
         end
      end
   end

   // Period and duty writes land here; channels buffer them
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < NUM_CH; i++) begin
            channel_period_value[i] <= PERIOD_RST;
            channel_duty_value[i]   <= DUTY_RST;
         end
      end else if (wr) begin
         if (hit_per) begin
            channel_period_value[ch_sel] <= wr_data;
         end
         if (hit_duty) begin
            channel_duty_value[ch_sel] <= wr_data;
         end
      end
   end

   // Test bits live only in special mode
   always_ff @(posedge clk) begin
      if (srst || special_mode_n) begin
         pwm_test_control <= 3'h0;
      end else if (wr_test_ok) begin
         pwm_test_control <= wr_data[7:5];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port data and direction
   always_ff @(posedge clk) begin
      if (srst) begin
         port_pin_data      <= PORT_RST;
         port_pin_direction <= DIR_RST;
      end else if (wr) begin
         if (hit_pdata) begin
            port_pin_data <= wr_data;
         end
         if (hit_pdir) begin
            port_pin_direction <= wr_data;
         end
      end
   end

   // Input bits show the pin, output bits the latch
   wire [7:0]   pin_level = {4'h0, pin_in};
   pwmtp_byte_t port_read;
   assign port_read = (port_pin_direction & port_pin_data)
                    | (~port_pin_direction & pin_level);

   // Pin drive: enabled channel wins, else direction bit
   logic [3:0] next_pin_out;
   logic [3:0] next_pin_oe_n;
   assign next_pin_out  = (ch_enable & ch_out) | (~ch_enable & port_pin_data[3:0]);
   assign next_pin_oe_n = ~(ch_enable | port_pin_direction[3:0]);

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_out  <= 4'h0;
         pin_oe_n <= 4'hF;
      end else begin
         pin_out  <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path
   pwmtp_byte_t next_rd_data;

   always_comb begin
      if (hit_enable) begin
         next_rd_data = {4'h0, ch_enable};
      end else if (hit_polarity) begin
         next_rd_data = {4'h0, ch_polarity};
      end else if (hit_pre_a) begin
         next_rd_data = prescale_divider_a;
      end else if (hit_scnt_a) begin
         next_rd_data = scale_cnt_a;
      end else if (hit_pre_b) begin
         next_rd_data = prescale_divider_b;
      end else if (hit_scnt_b) begin
         next_rd_data = scale_cnt_b;
      end else if (hit_cnt) begin
         next_rd_data = ch_count[ch_sel];
      end else if (hit_per) begin
         next_rd_data = channel_period_value[ch_sel];
      end else if (hit_duty) begin
         next_rd_data = channel_duty_value[ch_sel];
      end else if (hit_ctrl) begin
         next_rd_data = pwm_ctrl;
      end else if (hit_test) begin
         next_rd_data = {pwm_test_control, 5'h00};
      end else if (hit_pdata) begin
         next_rd_data = port_read;
      end else if (hit_pdir) begin
         next_rd_data = port_pin_direction;
      end else begin
         next_rd_data = BYTE_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data <= BYTE_ZERO;
      end else begin
         rd_data <= rd ? next_rd_data : BYTE_ZERO;
      end
   end
endmodule // pwmtp_top

// ### pwmtp_top_properties.sv
/* Checker for pwmtp_top: test register, port P pins and reads, ch0 boundary levels.
   Assumes one clock, srst synchronous active high, held for many cycles. */
`timescale 1ns/1ns
module pwmtp_top_properties (
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   srst,
   // Register bus
   input wire pwmtp_pkg::pwmtp_byte_t addr,
   input wire pwmtp_pkg::pwmtp_byte_t wr_data,
   input wire logic                   wr,
   input wire logic                   rd,
   input wire pwmtp_pkg::pwmtp_byte_t rd_data,
   // Chip mode
   input wire logic                   special_mode_n,
   // Port pins
   input wire logic [3:0]             pin_in,
   input wire logic [3:0]             pin_out,
   input wire logic [3:0]             pin_oe_n
);
   import pwmtp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   pwmtp_byte_t en_q, pol_q, dir_q, dat_q, tst_q, ctl_q, per_q, dty_q;
   ////////////////////////////////////////
   // Shadow of the registers seen at the bus
   always_ff @(posedge clk) begin
      if (srst) begin
         {en_q, pol_q, dir_q, dat_q, ctl_q} <= '0;
         per_q <= PERIOD_RST;
         dty_q <= DUTY_RST;
      end else if (wr) begin
         if (addr == ADDR_CH_ENABLE) en_q <= wr_data;
         if (addr == ADDR_CH_POLARITY) pol_q <= wr_data;
         if (addr == ADDR_PORT_DIR) dir_q <= wr_data;
         if (addr == ADDR_PORT_DATA) dat_q <= wr_data;
         if (addr == ADDR_PWM_CTRL) ctl_q <= wr_data;
         if (addr == ADDR_PER_BASE) per_q <= wr_data;
         if (addr == ADDR_DUTY_BASE) dty_q <= wr_data;
      end
   end
   always_ff @(posedge clk) begin
      if (srst || special_mode_n) tst_q <= BYTE_ZERO;
      else if (wr && addr == ADDR_TEST) tst_q <= wr_data & TEST_MASK;
   end
   wire [3:0] drv = en_q[3:0] | dir_q[3:0];
   wire [3:0] gpo = dir_q[3:0] & ~en_q[3:0];
   wire [7:0] prd = (dir_q & dat_q) | (~dir_q & {4'h0, pin_in});
   wire on1 = en_q[0] && pol_q[0];
   wire lft_ff = on1 && !ctl_q[CTRL_CENTER_BIT] && dty_q == BYTE_MAX && per_q != BYTE_ZERO;
   wire ctr_00 = on1 && ctl_q[CTRL_CENTER_BIT] && dty_q == BYTE_ZERO && per_q != BYTE_ZERO;
   wire per_00 = on1 && per_q == BYTE_ZERO;
   ////////////////////////////////////////
   sequence s_norm_test_rd;
      special_mode_n ##1 (special_mode_n && rd && addr == ADDR_TEST);
   endsequence
   a_test_normal_zero: assert property (s_norm_test_rd |=> rd_data == BYTE_ZERO)
      else $error("test register not clear in normal mode");
   a_test_readback: assert property (rd && addr == ADDR_TEST |=> rd_data == $past(tst_q))
      else $error("test register read wrong");
   a_reset_pins: assert property ($fell(srst) |-> pin_oe_n == 4'hF && pin_out == 4'h0)
      else $error("pins not released after reset");
   a_pin_enable: assert property (pin_oe_n == ~$past(drv))
      else $error("pin drive enable wrong");
   a_gpio_drive: assert property ((pin_out & $past(gpo)) == ($past(dat_q[3:0]) & $past(gpo)))
      else $error("port output level wrong");
   a_port_read: assert property (rd && addr == ADDR_PORT_DATA |=> rd_data == $past(prd))
      else $error("port data read wrong");
   a_dir_read: assert property (rd && addr == ADDR_PORT_DIR |=> rd_data == $past(dir_q))
      else $error("direction read wrong");
   a_left_ff_low: assert property (lft_ff [*8] |-> !pin_out[0])
      else $error("left duty max not low");
   a_ctr_zero_low: assert property (ctr_00 [*8] |-> !pin_out[0])
      else $error("centre duty zero not low");
   a_per_zero_high: assert property (per_00 [*8] |-> pin_out[0])
      else $error("period zero not high");
endmodule // pwmtp_top_properties

bind pwmtp_top pwmtp_top_properties pwmtp_top_properties_inst (.clk(clk), .srst(srst),
   .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd), .rd_data(rd_data),
   .special_mode_n(special_mode_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ### pwmtp_pin_model.sv
/* External side of port pins 3..0: resolves device drive and outside drive.
   Assumes outside drivers release a pin whenever the device drives it. */
`timescale 1ns/1ns
module pwmtp_pin_model (
   // Clock
   input  wire logic       clk,
   // Device side
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe_n,
   // Outside drive
   input  wire logic       ext_en,
   input  wire logic [3:0] ext_val,
   // Pin levels
   output      logic [3:0] pin_in
);
   logic [3:0] flt = 4'h5;
   // Undriven pin wanders every cycle
   always @(posedge clk) flt <= ~pin_in;
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (ext_en ? ext_val : flt));
endmodule // pwmtp_pin_model

// ### tb_pwm_test_port_boundary.sv
/* Self-checking bench for pwmtp_top: bus tasks, read queue, pin checks.
   Assumes a 250 MHz clock and the pin model on the port. */
`timescale 1ns/1ns
module tb_pwm_test_port_boundary;
   import pwmtp_pkg::*;
   typedef struct {logic [1:0] m; pwmtp_byte_t v;} pwmtp_exp_s;
   logic        clk, srst, wr, rd, special_mode_n, ext_en, seen;
   pwmtp_byte_t addr, wr_data, rd_data, d, p, got;
   logic [3:0]  pin_in, pin_out, pin_oe_n, ext_val;
   int          errors, total_checks, seed, i, n;
   pwmtp_exp_s  exq[$];
   pwmtp_exp_s  e;
   // Center, polarity, expected level, duty, period
   logic [18:0] bt [10] = '{{3'b010, 8'hFF, 8'h05}, {3'b001, 8'hFF, 8'h05},
      {3'b011, 8'h07, 8'h05}, {3'b000, 8'h07, 8'h05}, {3'b011, 8'h03, 8'h00},
      {3'b000, 8'h03, 8'h00}, {3'b110, 8'h00, 8'h05}, {3'b101, 8'h00, 8'h05},
      {3'b111, 8'h05, 8'h05}, {3'b100, 8'h09, 8'h00}};

   pwmtp_top pwmtp_top_inst (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data),
      .wr(wr), .rd(rd), .rd_data(rd_data), .special_mode_n(special_mode_n),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
   pwmtp_pin_model pwmtp_pin_model_inst (.clk(clk), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic put(input pwmtp_byte_t a, input pwmtp_byte_t v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Mode 0 exact, 1 above v, 2 at most v
   task automatic get(input pwmtp_byte_t a, input logic [1:0] m, input pwmtp_byte_t v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exq.push_back('{m, v});
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic chk_pin(input logic [3:0] oe, input logic [3:0] o);
      @(negedge clk);
      total_checks++;
      if (pin_oe_n !== oe || pin_out !== o) begin
         errors++;
         $display("CHECK FAILED t=%0t pins %h/%h exp %h/%h", $time, pin_oe_n, pin_out, oe, o);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Read data stand in the cycle after the strobe
   always @(posedge clk) begin
      seen <= rd;
      if (seen) begin
         e = exq.pop_front();
         got = rd_data;
         total_checks++;
         if ($isunknown(got) || (e.m == 2'd0 && got !== e.v) || (e.m == 2'd1 && got <= e.v)
             || (e.m == 2'd2 && got > e.v)) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e.v);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end
   ////////////////////////////////////////
   initial begin
      {srst, special_mode_n, ext_en} = 3'b111;
      {wr, rd, addr, wr_data} = '0;
      {errors, total_checks} = '0;
      ext_val = 4'hA;
      seed = 32'h128a;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      chk_pin(4'hF, 4'h0);
      get(ADDR_PORT_DIR, 2'd0, DIR_RST);
      put(ADDR_TEST, BYTE_MAX);
      get(ADDR_TEST, 2'd0, BYTE_ZERO);
      special_mode_n <= 1'b0;
      put(ADDR_TEST, BYTE_MAX);
      get(ADDR_TEST, 2'd0, TEST_MASK);
      special_mode_n <= 1'b1;
      get(ADDR_TEST, 2'd0, BYTE_ZERO);
      for (i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         p = 8'($random(seed));
         ext_val <= 4'($random(seed));
         put(ADDR_PORT_DIR, d);
         put(ADDR_PORT_DATA, p);
         get(ADDR_PORT_DATA, 2'd0, (d & p) | (~d & {4'h0, ext_val}));
         get(ADDR_PORT_DIR, 2'd0, d);
         chk_pin(~d[3:0], p[3:0]);
      end
      put(ADDR_PORT_DIR, 8'h0F);
      put(ADDR_PRESCALE_A, BYTE_ZERO);
      for (i = 0; i < 10; i++) begin
         put(ADDR_CH_ENABLE, BYTE_ZERO);
         put(ADDR_PWM_CTRL, {4'h0, bt[i][18], 3'h0});
         put(ADDR_PER_BASE, bt[i][7:0]);
         put(ADDR_DUTY_BASE, bt[i][15:8]);
         put(ADDR_CH_POLARITY, {7'h00, bt[i][17]});
         put(ADDR_PORT_DATA, {7'h00, ~bt[i][16]});
         put(ADDR_CH_ENABLE, BYTE_ONE);
         repeat (40) @(posedge clk);
         chk_pin(4'h0, {3'h0, bt[i][16]});
      end
      put(ADDR_CH_ENABLE, BYTE_ZERO);
      special_mode_n <= 1'b0;
      put(ADDR_PWM_CTRL, BYTE_ZERO);
      put(ADDR_PER_BASE, 8'h05);
      put(ADDR_DUTY_BASE, 8'h02);
      put(ADDR_CNT_BASE, BYTE_ZERO);
      put(ADDR_TEST, 8'h40);
      put(ADDR_CH_ENABLE, BYTE_ONE);
      repeat (30) @(posedge clk);
      put(ADDR_CH_ENABLE, BYTE_ZERO);
      get(ADDR_CNT_BASE, 2'd1, 8'h05);
      put(ADDR_TEST, 8'h80);
      put(ADDR_CNT_BASE, BYTE_ZERO);
      get(ADDR_CNT_BASE, 2'd1, 8'h05);
      put(ADDR_TEST, BYTE_ZERO);
      put(ADDR_CNT_BASE, BYTE_ZERO);
      get(ADDR_CNT_BASE, 2'd0, BYTE_ZERO);
      put(ADDR_CH_ENABLE, BYTE_ONE);
      repeat (6) @(posedge clk);
      // Period 5, duty 2: three of every six cycles high
      n = 0;
      repeat (24) begin
         @(negedge clk);
         n += pin_out[0];
      end
      total_checks++;
      if (n != 12) begin
         errors++;
         $display("CHECK FAILED t=%0t highs %h exp %h", $time, n, 12);
      end
      put(ADDR_CH_ENABLE, BYTE_ZERO);
      get(ADDR_CNT_BASE, 2'd2, 8'h05);
      put(ADDR_PRESCALE_A, BYTE_MAX);
      put(ADDR_TEST, 8'h20);
      put(ADDR_PRESCALE_A, BYTE_ZERO);
      get(ADDR_SCALE_CNT_A, 2'd1, BYTE_ZERO);
      put(ADDR_TEST, BYTE_ZERO);
      put(ADDR_PRESCALE_A, BYTE_ZERO);
      get(ADDR_SCALE_CNT_A, 2'd0, BYTE_ZERO);
      put(ADDR_SCALE_CNT_A, 8'h33);
      put(8'h60, 8'h5A);
      get(ADDR_SCALE_CNT_A, 2'd0, BYTE_ZERO);
      get(8'h60, 2'd0, BYTE_ZERO);
      special_mode_n <= 1'b1;
      repeat (4) @(posedge clk);
      print_verdict();
   end
endmodule // tb_pwm_test_port_boundary
